// ===== hw/lcbb_pkg.sv
// Constants, command codes and carrier types for the LCD timing and bank controller.
// Assumes a single 20 MHz system clock; every slower rate is an enable pulse.
package lcbb_pkg;

	// System clock and derived oscillator timing.
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int OSC_PRESCALE = 64;
	localparam int CLK_HZ_FF_HIGH = 3600;
	localparam int CLK_HZ_FF_LOW = 5280;
	localparam int OSC_CYC_FF_HIGH = SYS_CLK_HZ / (CLK_HZ_FF_HIGH * OSC_PRESCALE);
	localparam int OSC_CYC_FF_LOW = SYS_CLK_HZ / (CLK_HZ_FF_LOW * OSC_PRESCALE);
	localparam logic [6:0] OSC_LAST_FF_HIGH = 7'(OSC_CYC_FF_HIGH - 1);
	localparam logic [6:0] OSC_LAST_FF_LOW = 7'(OSC_CYC_FF_LOW - 1);
	localparam logic [5:0] PRESCALE_LAST = 6'(OSC_PRESCALE - 1);

	// Frame and blink division of the logic clock.
	localparam int FRAME_DIV = 24;
	localparam logic [4:0] FRAME_LAST = 5'(FRAME_DIV - 1);
	localparam int BLINK_DIV_1 = 768;
	localparam int BLINK_DIV_2 = 1536;
	localparam int BLINK_DIV_3 = 3072;
	localparam logic [10:0] BLINK_HALF_1 = 11'(BLINK_DIV_1 / 2);
	localparam logic [10:0] BLINK_HALF_2 = 11'(BLINK_DIV_2 / 2);
	localparam logic [10:0] BLINK_HALF_3 = 11'(BLINK_DIV_3 / 2);

	// Backplane slot boundaries inside one frame.
	localparam logic [4:0] SLOT_DUP = 5'h0C;
	localparam logic [4:0] SLOT_TRI = 5'h08;
	localparam logic [4:0] SLOT_QUAD = 5'h06;

	// Display memory geometry.
	localparam int COLS = 80;
	localparam int ROWS = 4;
	localparam logic [6:0] COL_LAST = 7'(COLS - 1);

	// Command opcodes, compared against the upper bits of the byte.
	localparam logic [3:0] OP_MODE_SET = 4'hC;
	localparam logic [5:0] OP_DEV_SEL = 6'h38;
	localparam logic [5:0] OP_BANK_SEL = 6'h3E;
	localparam logic [4:0] OP_BLINK_SEL = 5'h1E;

	// Drive mode field codes.
	localparam logic [1:0] MODE_STATIC = 2'h1;
	localparam logic [1:0] MODE_DUP = 2'h2;
	localparam logic [1:0] MODE_TRI = 2'h3;
	localparam logic [1:0] MODE_QUAD = 2'h0;

	// Values after reset.
	localparam logic [1:0] RST_MODE = MODE_QUAD;
	localparam logic [1:0] RST_RATE = 2'h0;
	localparam logic [1:0] RST_SUBADDR = 2'h0;

	typedef enum logic [1:0] {
		SCAN_IDLE = 2'b01,
		SCAN_RUN = 2'b10
	} lcbb_scan_e;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} lcbb_cmd_s;

	typedef struct packed {
		logic valid;
		logic [6:0] col;
		logic [3:0] bits;
	} lcbb_wr_s;

endpackage

// ===== hw/lcbb_ram.sv
// Display memory of 80 columns by 4 rows with a masked write port.
// Assumes one write and one read per clock; read data come from a register.
`timescale 1ns/100ps
module lcbb_ram
	import lcbb_pkg::*;
(
	// Clock.
	input wire logic i_sys_clk,
	// Write port.
	input wire logic i_we,
	input wire logic [6:0] i_wcol,
	input wire logic [3:0] i_wmask,
	input wire logic [3:0] i_wdata,
	// Read port.
	input wire logic [6:0] i_rcol,
	output logic [3:0] o_rdata
);

	logic [3:0] mem [COLS];

	always_ff @(posedge i_sys_clk) begin
		if (i_we && i_wcol <= COL_LAST) begin
			mem[i_wcol] <= (mem[i_wcol] & ~i_wmask) | (i_wdata & i_wmask);
		end
		o_rdata <= (i_rcol <= COL_LAST) ? mem[i_rcol] : 4'h0;
	end

endmodule // lcbb_ram

// ===== hw/lcbb_ctrl.sv
// Command decoding, clock and frame timing, blinking and display output for the LCD driver.
// Assumes a serial front end that hands over command bytes and column-addressed data.
`timescale 1ns/100ps
module lcbb_ctrl
	import lcbb_pkg::*;
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Command and display data from the serial front end.
	input wire lcbb_cmd_s i_cmd,
	input wire lcbb_wr_s i_wr,
	input wire logic i_ptr_wrap,
	// Straps.
	input wire logic i_osc_sel,
	input wire logic i_frame_rate_sel,
	input wire logic [1:0] i_hw_subaddr_pins,
	// Clock pin.
	input wire logic i_clk_pin,
	output logic o_clk_pin,
	output logic o_clk_oe_n,
	// Cascade sync pin, open drain.
	input wire logic i_sync_n,
	output logic o_sync_n,
	output logic o_sync_oe_n,
	// LCD drive, a 1 stands for the supply level.
	output logic [3:0] o_backplane_out,
	output logic [79:0] o_segment_out,
	output logic o_bias_half,
	// Status.
	output logic o_frame_freq,
	output logic [1:0] o_subaddr
);

	function automatic logic is_multi(input logic [1:0] mode);
		return (mode == MODE_TRI) || (mode == MODE_QUAD);
	endfunction

	function automatic logic [10:0] blink_half(input logic [1:0] rate);
		case (rate)
			2'h1: return BLINK_HALF_1;
			2'h2: return BLINK_HALF_2;
			default: return BLINK_HALF_3;
		endcase
	endfunction

	function automatic logic [1:0] bp_of(input logic [1:0] mode, input logic [4:0] ph);
		case (mode)
			MODE_STATIC: return 2'h0;
			MODE_DUP: return (ph < SLOT_DUP) ? 2'h0 : 2'h1;
			MODE_TRI: return (ph < SLOT_TRI) ? 2'h0 : (ph < 5'(2 * SLOT_TRI)) ? 2'h1 : 2'h2;
			default: return (ph < SLOT_QUAD) ? 2'h0 : (ph < 5'(2 * SLOT_QUAD)) ? 2'h1 :
				(ph < 5'(3 * SLOT_QUAD)) ? 2'h2 : 2'h3;
		endcase
	endfunction

	// Control state loaded by commands.
	logic [1:0] subaddr, next_subaddr;
	logic in_bank, next_in_bank;
	logic out_bank, next_out_bank;
	logic alt_blink, next_alt_blink;
	logic [1:0] rate, next_rate;
	logic disp_en, next_disp_en;
	logic bias_half, next_bias_half;
	logic [1:0] mode, next_mode;

	always_comb begin
		next_subaddr = subaddr;
		next_in_bank = in_bank;
		next_out_bank = out_bank;
		next_alt_blink = alt_blink;
		next_rate = rate;
		next_disp_en = disp_en;
		next_bias_half = bias_half;
		next_mode = mode;
		if (i_ptr_wrap) begin
			next_subaddr = subaddr + 2'h1;
		end
		if (i_cmd.valid) begin
			if (i_cmd.data[7:4] == OP_MODE_SET) begin
				next_disp_en = i_cmd.data[3];
				next_bias_half = i_cmd.data[2];
				next_mode = i_cmd.data[1:0];
			end else if (i_cmd.data[7:2] == OP_DEV_SEL) begin
				next_subaddr = i_cmd.data[1:0];
			end else if (i_cmd.data[7:2] == OP_BANK_SEL) begin
				if (!is_multi(mode)) begin
					next_in_bank = i_cmd.data[1];
					next_out_bank = i_cmd.data[0];
				end
			end else if (i_cmd.data[7:3] == OP_BLINK_SEL) begin
				next_alt_blink = i_cmd.data[2];
				next_rate = i_cmd.data[1:0];
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			subaddr <= RST_SUBADDR;
			in_bank <= 1'b0;
			out_bank <= 1'b0;
			alt_blink <= 1'b0;
			rate <= RST_RATE;
			disp_en <= 1'b0;
			bias_half <= 1'b0;
			mode <= RST_MODE;
		end else begin
			subaddr <= next_subaddr;
			in_bank <= next_in_bank;
			out_bank <= next_out_bank;
			alt_blink <= next_alt_blink;
			rate <= next_rate;
			disp_en <= next_disp_en;
			bias_half <= next_bias_half;
			mode <= next_mode;
		end
	end

	// Display data write. Only the row bank is chosen here; column stepping belongs
	// to the front end, which reports wraps that advance the subaddress here.
	logic ram_we;
	logic [3:0] wmask;
	logic [3:0] wdata;
	logic [3:0] rdata;
	logic [6:0] scan_col, next_scan_col;

	always_comb begin
		ram_we = i_wr.valid && (subaddr == i_hw_subaddr_pins);
		case (mode)
			MODE_STATIC: begin
				wmask = in_bank ? 4'h4 : 4'h1;
				wdata = in_bank ? {1'b0, i_wr.bits[0], 2'h0} : {3'h0, i_wr.bits[0]};
			end
			MODE_DUP: begin
				wmask = in_bank ? 4'hC : 4'h3;
				wdata = in_bank ? {i_wr.bits[1:0], 2'h0} : {2'h0, i_wr.bits[1:0]};
			end
			MODE_TRI: begin
				wmask = 4'h7;
				wdata = i_wr.bits;
			end
			default: begin
				wmask = 4'hF;
				wdata = i_wr.bits;
			end
		endcase
	end

	lcbb_ram u_ram (
		.i_sys_clk(i_sys_clk),
		.i_we(ram_we),
		.i_wcol(i_wr.col),
		.i_wmask(wmask),
		.i_wdata(wdata),
		.i_rcol(scan_col),
		.o_rdata(rdata)
	);

	// Logic clock: internal oscillator divided by 64, or the clock pin itself.
	logic [6:0] osc_cnt, next_osc_cnt;
	logic [5:0] pre_cnt, next_pre_cnt;
	logic clk_pin_d, next_clk_pin_d;
	logic osc_pulse;
	logic tick;

	always_comb begin
		logic [6:0] osc_last;
		osc_last = i_frame_rate_sel ? OSC_LAST_FF_HIGH : OSC_LAST_FF_LOW;
		osc_pulse = !i_osc_sel && (osc_cnt >= osc_last);
		next_osc_cnt = (osc_pulse || i_osc_sel) ? 7'h00 : osc_cnt + 7'h01;
		next_pre_cnt = osc_pulse ? pre_cnt + 6'h01 : pre_cnt;
		next_clk_pin_d = i_clk_pin;
		if (i_osc_sel) begin
			tick = i_clk_pin && !clk_pin_d;
		end else begin
			tick = osc_pulse && (pre_cnt == PRESCALE_LAST);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			osc_cnt <= 7'h00;
			pre_cnt <= 6'h00;
			clk_pin_d <= 1'b0;
		end else begin
			osc_cnt <= next_osc_cnt;
			pre_cnt <= next_pre_cnt;
			clk_pin_d <= next_clk_pin_d;
		end
	end

	// Frame phase, sync alignment and blink timebase, all stepped by the logic clock.
	logic [4:0] phase, next_phase;
	logic [10:0] blink_cnt, next_blink_cnt;
	logic blink_ph, next_blink_ph;
	logic realign;
	logic scan_start;

	always_comb begin
		next_phase = phase;
		next_blink_cnt = blink_cnt;
		next_blink_ph = blink_ph;
		// Another device pulling sync low outside our phase 0 marks its frame start.
		realign = tick && !i_sync_n && (phase != 5'h00);
		if (realign) begin
			next_phase = 5'h01;
		end else if (tick) begin
			next_phase = (phase == FRAME_LAST) ? 5'h00 : phase + 5'h01;
		end
		scan_start = realign || (tick && next_phase == 5'h00);
		if (i_cmd.valid && i_cmd.data[7:3] == OP_BLINK_SEL) begin
			next_blink_cnt = 11'h000;
			next_blink_ph = 1'b0;
		end else if (rate == 2'h0) begin
			next_blink_cnt = 11'h000;
			next_blink_ph = 1'b0;
		end else if (tick) begin
			if (blink_cnt >= blink_half(rate) - 11'h001) begin
				next_blink_cnt = 11'h000;
				next_blink_ph = !blink_ph;
			end else begin
				next_blink_cnt = blink_cnt + 11'h001;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			phase <= 5'h00;
			blink_cnt <= 11'h000;
			blink_ph <= 1'b0;
		end else begin
			phase <= next_phase;
			blink_cnt <= next_blink_cnt;
			blink_ph <= next_blink_ph;
		end
	end

	// Once per frame the memory is copied into the output image, so every
	// cascaded device switches to new data at the same frame boundary.
	lcbb_scan_e scan_state, next_scan_state;
	logic scan_vld, next_scan_vld;
	logic [6:0] scan_col_d, next_scan_col_d;
	logic [3:0][79:0] img, next_img;

	always_comb begin
		next_scan_state = scan_state;
		next_scan_col = scan_col;
		next_scan_vld = 1'b0;
		next_scan_col_d = scan_col;
		next_img = img;
		case (scan_state)
			SCAN_IDLE: begin
				if (scan_start) begin
					next_scan_state = SCAN_RUN;
					next_scan_col = 7'h00;
				end
			end
			SCAN_RUN: begin
				next_scan_vld = 1'b1;
				if (scan_col == COL_LAST) begin
					next_scan_state = SCAN_IDLE;
				end else begin
					next_scan_col = scan_col + 7'h01;
				end
			end
			default: begin
				next_scan_state = SCAN_IDLE;
			end
		endcase
		if (scan_vld) begin
			for (int r = 0; r < ROWS; r++) begin
				next_img[r][scan_col_d] = rdata[r];
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			scan_state <= SCAN_IDLE;
			scan_col <= 7'h00;
			scan_vld <= 1'b0;
			scan_col_d <= 7'h00;
			img <= '0;
		end else begin
			scan_state <= next_scan_state;
			scan_col <= next_scan_col;
			scan_vld <= next_scan_vld;
			scan_col_d <= next_scan_col_d;
			img <= next_img;
		end
	end

	// Output drive.
	logic blank;
	logic bank_eff;
	logic [1:0] bp;
	logic [1:0] row;
	logic [3:0] next_bp_out;
	logic [79:0] next_seg_out;
	logic next_clk_pin;
	logic next_sync_oe_n;
	logic next_frame_freq;

	always_comb begin
		// Whole-display blink has no effect in static or 1:2 drive.
		blank = !disp_en || (!alt_blink && rate != 2'h0 && is_multi(mode) && blink_ph);
		bank_eff = out_bank ^ (alt_blink && rate != 2'h0 && !is_multi(mode) && blink_ph);
		bp = bp_of(mode, phase);
		case (mode)
			MODE_STATIC: row = {bank_eff, 1'b0};
			MODE_DUP: row = {bank_eff, bp[0]};
			default: row = bp;
		endcase
		if (blank) begin
			next_bp_out = 4'hF;
			next_seg_out = '1;
		end else begin
			next_bp_out = 4'h1 << bp;
			next_seg_out = img[row];
		end
		next_clk_pin = pre_cnt[5];
		next_sync_oe_n = (phase != 5'h00);
		next_frame_freq = tick && (next_phase == 5'h00);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_backplane_out <= 4'hF;
			o_segment_out <= '1;
			o_clk_pin <= 1'b0;
			o_sync_oe_n <= 1'b1;
			o_frame_freq <= 1'b0;
		end else begin
			o_backplane_out <= next_bp_out;
			o_segment_out <= next_seg_out;
			o_clk_pin <= next_clk_pin;
			o_sync_oe_n <= next_sync_oe_n;
			o_frame_freq <= next_frame_freq;
		end
	end

	assign o_clk_oe_n = i_osc_sel;
	assign o_sync_n = 1'b0;
	assign o_bias_half = bias_half;
	assign o_subaddr = subaddr;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	property p_dev_sel;
		i_cmd.valid && i_cmd.data[7:2] == OP_DEV_SEL |=> subaddr == $past(i_cmd.data[1:0]);
	endproperty
	a_dev_sel: assert property (p_dev_sel) else $error("subaddress not loaded");

	property p_bank_load;
		i_cmd.valid && i_cmd.data[7:2] == OP_BANK_SEL && !is_multi(mode)
			|=> in_bank == $past(i_cmd.data[1]) && out_bank == $past(i_cmd.data[0]);
	endproperty
	a_bank_load: assert property (p_bank_load) else $error("bank select not loaded");

	property p_bank_ignored;
		i_cmd.valid && i_cmd.data[7:2] == OP_BANK_SEL && is_multi(mode)
			|=> $stable(in_bank) && $stable(out_bank);
	endproperty
	a_bank_ignored: assert property (p_bank_ignored) else $error("bank select acted");

	property p_blink_load;
		i_cmd.valid && i_cmd.data[7:3] == OP_BLINK_SEL
			|=> rate == $past(i_cmd.data[1:0]) && alt_blink == $past(i_cmd.data[2]);
	endproperty
	a_blink_load: assert property (p_blink_load) else $error("blink select not loaded");

	property p_frame_wrap;
		tick && phase == FRAME_LAST && i_sync_n |=> phase == 5'h00 && o_frame_freq;
	endproperty
	a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap at 24");

	property p_disabled_blank;
		!disp_en ##1 !disp_en |-> o_backplane_out == 4'hF && o_segment_out == '1;
	endproperty
	a_disabled_blank: assert property (p_disabled_blank) else $error("disabled display shown");

	property p_store_gate;
		i_wr.valid && subaddr != i_hw_subaddr_pins |-> !ram_we;
	endproperty
	a_store_gate: assert property (p_store_gate) else $error("store with subaddress mismatch");

	property p_normal_blink_mode;
		blank && disp_en |-> is_multi(mode) && !alt_blink;
	endproperty
	a_normal_blink_mode: assert property (p_normal_blink_mode) else $error("blink blanked wrongly");

	property p_blink_half;
		tick && rate != 2'h0 && blink_cnt == blink_half(rate) - 11'h001
			&& !(i_cmd.valid && i_cmd.data[7:3] == OP_BLINK_SEL)
			|=> blink_ph != $past(blink_ph) && blink_cnt == 11'h000;
	endproperty
	a_blink_half: assert property (p_blink_half) else $error("blink half period wrong");

	property p_ext_clk_tick;
		i_osc_sel && i_clk_pin && !clk_pin_d |-> tick;
	endproperty
	a_ext_clk_tick: assert property (p_ext_clk_tick) else $error("external edge not used");

endmodule // lcbb_ctrl

// ===== sim/lcbb_cascade_peer.sv
// Far-side model: a cascaded companion that supplies the clock and shares the sync wire.
// Assumes the bench system clock; the peer clock period is four system cycles.
`timescale 1ns/100ps
module lcbb_cascade_peer (
	// System clock.
	input wire logic i_sys_clk,
	// Bench request for one sync pull.
	input wire logic i_sync_req,
	// Device pins.
	input wire logic i_dev_clk,
	input wire logic i_dev_clk_oe_n,
	input wire logic i_dev_sync_oe_n,
	// Resolved wires.
	output logic o_clk_wire,
	output logic o_sync_wire
);
	logic [1:0] div = 2'h0;
	logic pull = 1'b0;
	logic armed = 1'b0;
	// The peer clock never stops, so the glass is never left in a DC state.
	always @(posedge i_sys_clk) begin
		div <= div + 2'h1;
		// A pull spans falling edge to falling edge, so exactly one rising edge sees it.
		// A request in the cycle that opens a pull goes straight out instead of being lost.
		if (div == 2'h3) begin
			pull <= armed || i_sync_req;
			armed <= 1'b0;
		end else if (i_sync_req) begin
			armed <= 1'b1;
		end
	end
	assign o_clk_wire = i_dev_clk_oe_n ? div[1] : i_dev_clk;
	// Open drain with pull-up: low when either party pulls.
	assign o_sync_wire = !(pull || !i_dev_sync_oe_n);
endmodule // lcbb_cascade_peer

// ===== sim/tb.sv
// Self-checking bench for the LCD timing and bank controller.
// Assumes the peer model supplies the cascade clock and resolves the sync wire.
`timescale 1ns/100ps
module tb;
	import lcbb_pkg::*;
	localparam int TICK = 4;
	localparam int LIMIT = 90000;
	logic i_sys_clk = 1'b0;
	logic i_nrst = 1'b0;
	lcbb_cmd_s i_cmd = '0;
	lcbb_wr_s i_wr = '0;
	logic i_ptr_wrap = 1'b0;
	logic i_osc_sel = 1'b1;
	logic i_frame_rate_sel = 1'b1;
	logic [1:0] i_hw_subaddr_pins = 2'h0;
	logic sync_req = 1'b0;
	logic clk_wire, sync_wire, o_clk_pin, o_clk_oe_n, o_sync_oe_n, o_frame_freq, o_bias_half;
	logic [3:0] o_backplane_out;
	logic [79:0] o_segment_out;
	logic [1:0] o_subaddr;
	logic [1:0] wsel = 2'h0;
	logic [3:0] mask;
	logic probe;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	int n, m;
	logic [7:0] mcmd [4] = '{8'hCA, 8'hCF, 8'hC8, 8'hC9};
	logic [3:0] mexp [4] = '{4'h3, 4'h7, 4'hF, 4'h1};
	assign probe = (wsel == 2'h0) ? o_segment_out[5] :
		(wsel == 2'h1) ? (o_backplane_out === 4'hF) : o_clk_pin;
	always #25 i_sys_clk = ~i_sys_clk;
	lcbb_ctrl DUT (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cmd(i_cmd), .i_wr(i_wr),
		.i_ptr_wrap(i_ptr_wrap), .i_osc_sel(i_osc_sel), .i_frame_rate_sel(i_frame_rate_sel),
		.i_hw_subaddr_pins(i_hw_subaddr_pins), .i_clk_pin(clk_wire), .o_clk_pin(o_clk_pin),
		.o_clk_oe_n(o_clk_oe_n), .i_sync_n(sync_wire), .o_sync_n(), .o_sync_oe_n(o_sync_oe_n),
		.o_backplane_out(o_backplane_out), .o_segment_out(o_segment_out),
		.o_bias_half(o_bias_half),
		.o_frame_freq(o_frame_freq), .o_subaddr(o_subaddr));
	lcbb_cascade_peer u_peer (.i_sys_clk(i_sys_clk), .i_sync_req(sync_req), .i_dev_clk(o_clk_pin),
		.i_dev_clk_oe_n(o_clk_oe_n), .i_dev_sync_oe_n(o_sync_oe_n), .o_clk_wire(clk_wire),
		.o_sync_wire(sync_wire));
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_val(input logic [79:0] got, input logic [79:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_near(input int got, input int exp, input int tol, input string what);
		checked++;
		if (got < exp - tol || got > exp + tol) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s took %0d expected %0d", $time, what, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] b);
		@(negedge i_sys_clk);
		i_cmd <= '{valid: 1'b1, data: b};
		@(negedge i_sys_clk);
		i_cmd <= '0;
		@(negedge i_sys_clk);
	endtask
	task automatic wr(input logic [6:0] col, input logic [3:0] bits);
		@(negedge i_sys_clk);
		i_wr <= '{valid: 1'b1, col: col, bits: bits};
		@(negedge i_sys_clk);
		i_wr <= '0;
	endtask
	// Cycles until the next frame pulse.
	task automatic next_pulse(output int c);
		c = 0;
		do begin
			@(negedge i_sys_clk);
			c++;
		end while (o_frame_freq !== 1'b1 && c < 2000);
	endtask
	// Cycles until the probe changes, or the limit when it holds still.
	task automatic gap(input int lim, output int c);
		logic v;
		v = probe;
		c = 0;
		do begin
			@(negedge i_sys_clk);
			c++;
		end while (probe === v && c < lim);
	endtask
	task automatic frames(input int k);
		repeat (k) next_pulse(n);
		repeat (2 * TICK) @(negedge i_sys_clk);
	endtask
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			$display("CHECK FAILED at %0t: run did not finish in time", $time);
			stop_test();
		end
	end
	initial begin
		repeat (5) @(negedge i_sys_clk);
		chk_val(80'(o_backplane_out), 80'hF, "blank backplanes");
		chk_val(o_segment_out, {80{1'b1}}, "blank segments");
		chk_val(80'(o_clk_oe_n), 80'h1, "clock pin as input");
		@(negedge i_sys_clk);
		i_nrst <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			cmd({6'h38, 2'(i)});
			chk_val(80'(o_subaddr), 80'(i), "subaddress");
		end
		cmd(8'hE2);
		i_ptr_wrap <= 1'b1;
		@(negedge i_sys_clk);
		i_ptr_wrap <= 1'b0;
		@(negedge i_sys_clk);
		chk_val(80'(o_subaddr), 80'h3, "subaddress after wrap");
		cmd(8'hE1);
		wr(7'd9, 4'h1);
		cmd(8'hE0);
		cmd(8'hC9);
		wr(7'd5, 4'h1);
		cmd(8'hFA);
		wr(7'd7, 4'h1);
		frames(3);
		chk_val(80'(o_backplane_out), 80'h1, "static backplane");
		chk_val(o_segment_out, 80'h20, "output bank 0");
		cmd(8'hF9);
		frames(3);
		chk_val(o_segment_out, 80'h80, "output bank 1");
		cmd(8'hC8);
		cmd(8'hF8);
		cmd(8'hC9);
		frames(3);
		chk_val(o_segment_out, 80'h80, "bank command in 1:4");
		// Host blanking by the enable bit, the way a custom blink rate is made.
		cmd(8'hC1);
		frames(3);
		chk_val(80'(o_backplane_out), 80'hF, "disabled backplanes");
		chk_val(o_segment_out, {80{1'b1}}, "disabled segments");
		for (int i = 0; i < 4; i++) begin
			cmd(mcmd[i]);
			frames(2);
			mask = 4'h0;
			repeat (24 * TICK) begin
				@(negedge i_sys_clk);
				mask |= o_backplane_out;
			end
			chk_val(80'(mask), 80'(mexp[i]), "backplanes in use");
			chk_val(80'(o_bias_half), 80'(mcmd[i][2]), "bias bit");
		end
		next_pulse(n);
		next_pulse(n);
		chk_near(n, 24 * TICK, 0, "frame period");
		i_frame_rate_sel <= 1'b0;
		next_pulse(n);
		next_pulse(n);
		chk_near(n, 24 * TICK, 0, "frame period, select low");
		repeat (10 * TICK) @(negedge i_sys_clk);
		sync_req <= 1'b1;
		@(negedge i_sys_clk);
		sync_req <= 1'b0;
		next_pulse(n);
		chk_near(n, 24 * TICK, 2 * TICK, "frame after sync");
		for (int r = 1; r < 4; r++) begin
			cmd({5'h1E, 1'b1, 2'(r)});
			gap(7000, n);
			gap(7000, n);
			gap(7000, m);
			chk_near(n, (384 * TICK) << (r - 1), 24 * TICK, "bank swap");
			chk_near(m, n, 24 * TICK, "bank swap duty");
		end
		cmd(8'hF4);
		gap(2000, n);
		chk_near(n, 2000, 0, "blink off");
		cmd(8'hF1);
		gap(2000, n);
		chk_near(n, 2000, 0, "normal blink in static");
		cmd(8'hC8);
		wsel = 2'h1;
		cmd(8'hF1);
		gap(7000, n);
		gap(7000, n);
		gap(7000, m);
		chk_near(n, 384 * TICK, 24 * TICK, "whole display blink");
		chk_near(m, n, 24 * TICK, "blank duty");
		cmd(8'hF0);
		// Group blinking in 1:4 mode: the host rewrites the columns it wants to flash.
		for (int k = 0; k < 2; k++) begin
			wr(7'd5, k ? 4'h0 : 4'hF);
			frames(2);
			chk_val(o_segment_out & 80'h20, k ? 80'h0 : 80'h20, "host group blink");
		end
		i_osc_sel <= 1'b0;
		wsel = 2'h2;
		@(negedge i_sys_clk);
		chk_val(80'(o_clk_oe_n), 80'h0, "clock pin driven");
		for (int f = 1; f >= 0; f--) begin
			i_frame_rate_sel <= f[0];
			gap(7000, n);
			gap(7000, n);
			gap(7000, m);
			chk_near(n + m, (20000000 / ((f ? 3600 : 5280) * 64)) * 64, 2, "logic clock");
		end
		stop_test();
	end
endmodule // tb
